/* verilog/scp_pkg.sv */
// Package for the switch control serial port: frame layout, addresses and timing
package scp_pkg;

	// Frame geometry
	localparam int FRAME_BITS   = 16;
	localparam int ADDR_LSB     = 9;
	localparam int ADDR_W       = 4;
	localparam int WD_BIT       = 15;
	localparam int NUM_SI_REGS  = 16;
	localparam int NUM_SO_REGS  = 13;
	localparam int NUM_CH       = 2;

	// Read-back selection: this address echoes the previous input frame
	localparam logic [3:0] ADDR_ECHO     = 4'hf;
	localparam logic [3:0] ADDR_STATUS   = 4'h0;
	localparam logic [3:0] ADDR_CHFAULT0 = 4'h1;
	localparam logic [3:0] ADDR_CHFAULT1 = 4'h2;
	localparam logic [3:0] ADDR_DIAG     = 4'h3;
	localparam logic [3:0] ADDR_GCR      = 4'h4;

	// Global config field positions
	localparam int SENSE_EN0_POS = 0;
	localparam int SENSE_EN1_POS = 1;

	// Reset value of every serial register
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Timing at a 40 ns clock
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SLEEP_DELAY_US  = 200;
	localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int WDOG_TO_MS      = 32;
	localparam int WDOG_TO_CYC     = WDOG_TO_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CLKMON_US       = 100;
	localparam int CLKMON_CYC      = CLKMON_US * 1000 / CLK_PERIOD_NS;

	// Fault bit positions in the fault vector
	typedef struct packed {
		logic overcurrent;
		logic overtemp;
		logic short_supply;
		logic severe_short;
		logic open_load_while_on;
		logic open_load_while_off;
		logic clock_fail;
		logic overvoltage;
		logic undervoltage;
	} scp_fault_s;

	// Serial pin group after synchronisation
	typedef struct packed {
		logic chip_select_n;
		logic sclk;
		logic sdi;
	} scp_spi_s;

endpackage

/* verilog/scp_switch_port.sv */
// Serial control port, wake, watchdog and flag logic of a two-channel switch
`timescale 1ns/1ps
module scp_switch_port
	import scp_pkg::*;
#(
	parameter int SLEEP_CYC = SLEEP_DELAY_CYC,
	parameter int WDOG_CYC  = WDOG_TO_CYC
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset,
	// Serial pins, asynchronous
	input  wire logic                chip_select_n,
	input  wire logic                sclk,
	input  wire logic                sdi,
	output logic                     sdo_o,
	output logic                     sdo_oe,
	// Wake and direct control pins, asynchronous
	input  wire logic                reset_wake_n,
	input  wire logic [NUM_CH-1:0]   direct_in,
	input  wire logic [NUM_CH-1:0]   load_type_select,
	input  wire logic                pwm_clk_in,
	// Analog side status, same clock
	input  wire scp_fault_s          fault_in,
	input  wire logic                vdd_present,
	input  wire logic                oc_window,
	input  wire logic [NUM_CH-1:0]   sense_valid,
	// Open-drain flags: output enable high pulls the pin low
	output logic                     fault_flag_n_oe,
	output logic                     failsafe_flag_n_oe,
	output logic                     sync_n_oe,
	output logic                     sense_output_oe,
	// Channel control and state
	output logic [NUM_CH-1:0]        channel_on,
	output logic [NUM_CH-1:0]        motor_profile,
	output logic                     awake,
	output logic                     failsafe
);

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every pin input
	localparam int SW = 3 + 1 + 2 * NUM_CH + 1;
	logic [SW-1:0] meta_ff;
	logic [SW-1:0] sync_ff;
	logic [SW-1:0] prev_ff;

	// Pins gathered, passed through two stages, then one more for edge finding
	always_ff @(posedge ref_clk) begin
		meta_ff <= {chip_select_n, sclk, sdi, reset_wake_n, direct_in, load_type_select,
			pwm_clk_in};
		sync_ff <= meta_ff;
		prev_ff <= sync_ff;
	end

	scp_spi_s           spi;
	scp_spi_s           spi_prev;
	logic               rstw_n;
	logic               rstw_prev;
	logic [NUM_CH-1:0]  din;
	logic [NUM_CH-1:0]  din_prev;
	logic [NUM_CH-1:0]  ltype;
	logic               pclk;
	logic               pclk_prev;
	assign {spi, rstw_n, din, ltype, pclk}  = sync_ff;
	assign {spi_prev, rstw_prev, din_prev}  = prev_ff[SW-1:NUM_CH+1];   // Load type needs no edge
	assign pclk_prev                        = prev_ff[0];
	logic sel;
	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	logic sck_rise;
	assign sel      = !spi.chip_select_n;
	assign cs_fall  = spi_prev.chip_select_n && !spi.chip_select_n;
	assign cs_rise  = !spi_prev.chip_select_n && spi.chip_select_n;
	assign sck_fall = sel && spi_prev.sclk && !spi.sclk;
	assign sck_rise = sel && !spi_prev.sclk && spi.sclk;

	////////////////////////////////////////////////////////////////////////
	// Serial shifter
	logic [FRAME_BITS-1:0] in_shift_ff;
	logic [FRAME_BITS-1:0] out_shift_ff;
	logic [FRAME_BITS-1:0] prev_frame_ff;
	logic [4:0]            bit_cnt_ff;
	logic [15:0]           si_regs_ff [NUM_SI_REGS];
	logic [15:0]           so_word;
	logic [3:0]            rd_addr;
	logic                  frame_ok;

	// Readout address is the address of the frame just latched
	assign rd_addr  = prev_frame_ff[ADDR_LSB +: ADDR_W];
	assign frame_ok = (bit_cnt_ff == 5'(FRAME_BITS));

	// Input shift on falling clock, counting bits; MSB arrives first
	always_ff @(posedge ref_clk) begin
		if (reset || cs_fall) begin
			bit_cnt_ff <= '0;
		end else if (sck_fall) begin
			in_shift_ff <= {in_shift_ff[FRAME_BITS-2:0], spi.sdi};
			if (bit_cnt_ff != 5'h1f) begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			end
		end
	end

	// Output shift: load on select fall, advance on rising clock
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_shift_ff <= REG_RESET;
		end else if (cs_fall) begin
			out_shift_ff <= so_word;
		end else if (sck_rise) begin
			out_shift_ff <= {out_shift_ff[FRAME_BITS-2:0], 1'b0};
		end
	end

	// Driver enabled only while selected; sense of MSB stands first
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sdo_oe <= 1'b0;
			sdo_o  <= 1'b0;
		end else begin
			sdo_oe <= sel && vdd_present;
			sdo_o  <= out_shift_ff[FRAME_BITS-1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input register file; a short frame is dropped rather than half-applied
	logic latch_en;
	assign latch_en = cs_rise && frame_ok;

	always_ff @(posedge ref_clk) begin
		if (reset || !rstw_n) begin
			for (int i = 0; i < NUM_SI_REGS; i++) begin
				si_regs_ff[i] <= REG_RESET;
			end
			prev_frame_ff <= REG_RESET;
		end else if (latch_en) begin
			si_regs_ff[in_shift_ff[ADDR_LSB +: ADDR_W]] <= in_shift_ff;
			prev_frame_ff <= in_shift_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky fault bits; set beats the read-clear of the same cycle
	scp_fault_s fault_ff;
	logic       rd_clear;
	logic       clk_fail;

	assign rd_clear = cs_fall && ((rd_addr == ADDR_STATUS) || (rd_addr == ADDR_CHFAULT0)
		|| (rd_addr == ADDR_CHFAULT1) || (rd_addr == ADDR_DIAG));

	always_ff @(posedge ref_clk) begin
		if (reset || !rstw_n) begin
			fault_ff <= '0;
		end else begin
			fault_ff <= (rd_clear ? '0 : fault_ff) | fault_in
				| scp_fault_s'({6'h00, clk_fail, 2'h0});
		end
	end

	// Readout mux: fault words, config, or the previous frame for chaining
	always_comb begin
		case (rd_addr)
			ADDR_STATUS:   so_word = {7'h00, fault_ff};
			ADDR_CHFAULT0: so_word = {10'h000, fault_ff[8:3]};
			ADDR_CHFAULT1: so_word = {10'h000, fault_ff[8:3]};
			ADDR_DIAG:     so_word = {13'h0000, fault_ff[2:0]};
			ADDR_ECHO:     so_word = prev_frame_ff;
			default:       so_word = si_regs_ff[rd_addr];
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Wake, sleep and watchdog
	typedef enum logic [1:0] {ST_SLEEP, ST_NORMAL, ST_FAILSAFE} scp_mode_e;
	scp_mode_e mode_ff;
	logic [31:0] sleep_cnt_ff;
	logic [31:0] wdog_cnt_ff;
	logic        wd_last_ff;
	logic        wd_armed_ff;
	logic        wake_rst;
	logic        wake_din;

	assign wake_rst = rstw_n && !rstw_prev;
	assign wake_din = |(din & ~din_prev);

	// Sleep countdown restarts on every direct input activity
	always_ff @(posedge ref_clk) begin
		if (reset || rstw_n || (|din)) begin
			sleep_cnt_ff <= '0;
		end else if (sleep_cnt_ff < 32'(SLEEP_CYC)) begin
			sleep_cnt_ff <= sleep_cnt_ff + 32'h1;
		end
	end

	// Watchdog: each good frame must flip the first bit within the timeout
	always_ff @(posedge ref_clk) begin
		if (reset || wake_rst || !rstw_n) begin
			wdog_cnt_ff <= '0;
			wd_armed_ff <= 1'b0;
			wd_last_ff  <= 1'b0;
		end else if (latch_en && (!wd_armed_ff || in_shift_ff[WD_BIT] != wd_last_ff)) begin
			wdog_cnt_ff <= '0;
			wd_armed_ff <= 1'b1;
			wd_last_ff  <= in_shift_ff[WD_BIT];
		end else if (wdog_cnt_ff < 32'(WDOG_CYC)) begin
			wdog_cnt_ff <= wdog_cnt_ff + 32'h1;
		end
	end

	// Mode sequencing
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_ff <= ST_SLEEP;
		end else begin
			case (mode_ff)
				ST_SLEEP: begin
					if (wake_rst || wake_din) begin
						mode_ff <= ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					if (rstw_n && (wdog_cnt_ff >= 32'(WDOG_CYC) || !vdd_present)) begin
						mode_ff <= ST_FAILSAFE;
					end else if (sleep_cnt_ff >= 32'(SLEEP_CYC)) begin
						mode_ff <= ST_SLEEP;
					end
				end
				ST_FAILSAFE: begin
					if (wake_rst) begin
						mode_ff <= ST_NORMAL;
					end else if (!rstw_n && sleep_cnt_ff >= 32'(SLEEP_CYC)) begin
						mode_ff <= ST_SLEEP;
					end
				end
				default: mode_ff <= ST_SLEEP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PWM clock monitor: no edge for the monitor window is a failure
	logic [15:0] clkmon_ff;
	assign clk_fail = (clkmon_ff >= 16'(CLKMON_CYC));

	always_ff @(posedge ref_clk) begin
		if (reset || (pclk != pclk_prev) || mode_ff == ST_SLEEP) begin
			clkmon_ff <= '0;
		end else if (!clk_fail) begin
			clkmon_ff <= clkmon_ff + 16'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel, flag and sense outputs
	logic [1:0] sense_en;
	assign sense_en = {si_regs_ff[ADDR_GCR][SENSE_EN1_POS], si_regs_ff[ADDR_GCR][SENSE_EN0_POS]};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			channel_on         <= '0;
			motor_profile      <= '1;
			awake              <= 1'b0;
			failsafe           <= 1'b0;
			fault_flag_n_oe    <= 1'b0;
			failsafe_flag_n_oe <= 1'b0;
			sense_output_oe    <= 1'b0;
			sync_n_oe          <= 1'b0;
		end else begin
			channel_on         <= (mode_ff == ST_SLEEP) ? '0 : din;
			motor_profile      <= ltype;
			awake              <= (mode_ff != ST_SLEEP);
			failsafe           <= (mode_ff == ST_FAILSAFE);
			fault_flag_n_oe    <= (|fault_ff);
			failsafe_flag_n_oe <= (mode_ff == ST_FAILSAFE);
			sense_output_oe    <= (sense_en != 2'h0) && !oc_window
				&& mode_ff == ST_NORMAL && vdd_present;
			// Release at any turn-off, pull low once sense is valid
			sync_n_oe          <= |(channel_on & ~din) ? 1'b0
				: (|(sense_valid & din) ? 1'b1 : sync_n_oe);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_cs_rise_good;
		cs_rise && frame_ok;
	endsequence

	AST_NO_SHIFT_DESEL: assert property (@(posedge ref_clk) disable iff (reset)
		!sel |=> $stable(bit_cnt_ff) && $stable(out_shift_ff)) else $error("shift while deselected");
	AST_LATCH: assert property (@(posedge ref_clk) disable iff (reset || !rstw_n)
		s_cs_rise_good |=> prev_frame_ff == $past(in_shift_ff)) else $error("no latch");
	AST_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
		cs_fall |=> out_shift_ff == $past(so_word)) else $error("no load");
	AST_TRISTATE: assert property (@(posedge ref_clk) disable iff (reset)
		!sel |=> !sdo_oe) else $error("output driven while deselected");
	AST_SHIFT_OUT: assert property (@(posedge ref_clk) disable iff (reset)
		sck_rise && !cs_fall |=> out_shift_ff[15:1] == $past(out_shift_ff[14:0]))
		else $error("output not shifted");
	AST_RESET_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		!rstw_n |=> prev_frame_ff == REG_RESET) else $error("register not reset");
	AST_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
		mode_ff == ST_SLEEP && wake_din |=> mode_ff == ST_NORMAL) else $error("no wake");
	AST_FAULT_FLAG: assert property (@(posedge ref_clk) disable iff (reset || !rstw_n)
		fault_in != '0 |=> ##1 fault_flag_n_oe) else $error("fault flag missed");
	AST_SENSE_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		sense_en == 2'h0 |=> !sense_output_oe) else $error("sense not tri-stated");
	AST_FS_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
		mode_ff == ST_FAILSAFE |=> failsafe_flag_n_oe) else $error("fail-safe flag missed");

endmodule

/* verif/scp_mcu_model.sv */
// Host controller model: serial bus master for the switch control port
`timescale 1ns/1ps
module scp_mcu_model (
	// Serial pins
	output logic      chip_select_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo_pin,
	input  wire logic sdo_oe
);
	logic wd_ff;
	logic oe_ok;

	// Idle: deselected, clock parked low
	initial begin
		chip_select_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		wd_ff = 1'b0;
		oe_ok = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One frame; phase offset keeps pin edges off the core clock edges
	task automatic xfer(input logic [15:0] tx, output logic [15:0] sent,
		output logic [15:0] rx);
		sent = tx;
		sent[15] = wd_ff;
		wd_ff = ~wd_ff;
		oe_ok = 1'b1;
		#407 chip_select_n = 1'b0;
		#400;
		// Data sampled late in the low phase: output lags the pin by ~4 cycles
		for (int i = 15; i >= 0; i--) begin
			#160 rx[i] = sdo_pin;
			oe_ok = oe_ok & sdo_oe;
			sclk = 1'b1;
			sdi = sent[i];
			#160 sclk = 1'b0;
		end
		#400 chip_select_n = 1'b1;
		sdi = ~sdi;
		#400;
	endtask

	// Clock and data activity while deselected
	task automatic noise;
		#7;
		for (int i = 0; i < 32; i++) begin
			#160 sclk = ~sclk;
			sdi = i[1];
		end
	endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the switch control serial port
`timescale 1ns/1ps
module tb_top;
	import scp_pkg::*;
	logic        ref_clk, reset, reset_wake_n, pwm_clk_in, pwm_run, vdd_present, oc_window;
	logic [1:0]  direct_in, load_type_select, sense_valid, channel_on, motor_profile;
	scp_fault_s  fault_in;
	wire         cs_n, sclk, sdi;
	logic        sdo_o, sdo_oe, sdo_last, ff_oe, fs_oe, sync_oe, sns_oe, awake, failsafe;
	logic [15:0] sent, rx;
	int          fail_count, checks, cyc;
	// Released serial output shows a changing level, never a stale bit
	wire         sdo_pin = sdo_oe ? sdo_o : ~sdo_last;
	// Open-drain pins with pull-ups
	wire         fault_flag_n = ~ff_oe;
	wire         failsafe_flag_n = ~fs_oe;

	scp_switch_port #(.SLEEP_CYC(20), .WDOG_CYC(400)) dut (.ref_clk(ref_clk),
		.reset(reset), .chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .reset_wake_n(reset_wake_n), .direct_in(direct_in),
		.load_type_select(load_type_select), .pwm_clk_in(pwm_clk_in), .fault_in(fault_in),
		.vdd_present(vdd_present), .oc_window(oc_window), .sense_valid(sense_valid),
		.fault_flag_n_oe(ff_oe), .failsafe_flag_n_oe(fs_oe), .sync_n_oe(sync_oe),
		.sense_output_oe(sns_oe), .channel_on(channel_on), .motor_profile(motor_profile),
		.awake(awake), .failsafe(failsafe));
	scp_mcu_model mcu (.chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_pin(sdo_pin),
		.sdo_oe(sdo_oe));

	////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// PWM clock source, hang limit and released-line memory
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (sdo_oe) sdo_last <= sdo_o;
		if (pwm_run && cyc % 50 == 0) pwm_clk_in <= ~pwm_clk_in;
		if (cyc == 40000) begin
			fail_count = fail_count + 1;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task stop_test;
		if (fail_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input logic ok, input string m);
		checks = checks + 1;
		if (ok !== 1'b1) begin
			fail_count = fail_count + 1;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task cyc_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	function automatic logic [15:0] fw(input logic [3:0] a, input logic [8:0] d);
		return {3'h0, a, d};
	endfunction

	// Frame, then realign to the core clock for the next stimulus
	task frm(input logic [15:0] w);
		mcu.xfer(w, sent, rx);
		@(posedge ref_clk);
	endtask

	task wake;
		reset_wake_n <= 1'b0;
		cyc_n(6);
		reset_wake_n <= 1'b1;
		cyc_n(10);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Settle margins of 12 cycles cover the input synchronisers
	task t_pins;
		cyc_n(60);
		chk(awake === 1'b0 && sdo_oe === 1'b0, "asleep");
		direct_in <= 2'b01;
		load_type_select <= 2'b10;
		cyc_n(12);
		chk(awake === 1'b1 && channel_on === 2'b01, "wake by input");
		chk(motor_profile === 2'b10, "load type");
		direct_in <= 2'b10;
		load_type_select <= 2'b01;
		cyc_n(12);
		chk(channel_on === 2'b10 && motor_profile === 2'b01, "direct");
		direct_in <= 2'b00;
		cyc_n(40);
		chk(awake === 1'b0 && channel_on === 2'b00, "sleep after delay");
	endtask

	task t_regs;
		logic [15:0] a, b;
		wake();
		frm(fw(4'h5, 9'h15a));
		a = sent;
		frm(fw(ADDR_ECHO, 9'h0a5));
		b = sent;
		chk(rx === a, "readback");
		mcu.noise();
		chk(sdo_oe === 1'b0, "released");
		frm(fw(4'h5, 9'h000));
		chk(rx === b && mcu.oe_ok === 1'b1, "echo");
		wake();
		frm(fw(4'h6, 9'h000));
		chk(rx === REG_RESET, "cleared");
	endtask

	task t_faults;
		// Point the readout at the status word so every later frame reads it
		frm(fw(ADDR_STATUS, 9'h000));
		for (int b = 0; b < 9; b++) begin
			fault_in <= scp_fault_s'(9'h001 << b);
			cyc_n(4);
			fault_in <= '0;
			cyc_n(12);
			chk(fault_flag_n === 1'b0, "flag low");
			frm(fw(ADDR_STATUS, 9'h000));
			chk(rx === {7'h00, 9'h001 << b} && fault_flag_n === 1'b1, "read clears");
		end
		// Starve the PWM clock past the monitor window
		pwm_run <= 1'b0;
		cyc_n(2700);
		chk(fault_flag_n === 1'b0, "clock fail");
		pwm_run <= 1'b1;
		cyc_n(200);
	endtask

	task t_sense;
		wake();
		direct_in <= 2'b01;
		frm(fw(ADDR_GCR, 9'h001));
		sense_valid <= 2'b01;
		cyc_n(12);
		chk(sns_oe === 1'b1 && sync_oe === 1'b1, "sense on");
		oc_window <= 1'b1;
		cyc_n(12);
		chk(sns_oe === 1'b0, "oc window");
		oc_window <= 1'b0;
		direct_in <= 2'b00;
		cyc_n(12);
		chk(sync_oe === 1'b0, "turn-off");
		frm(fw(ADDR_GCR, 9'h000));
		cyc_n(12);
		chk(sns_oe === 1'b0, "sense off");
		sense_valid <= 2'b00;
	endtask

	// Four toggled frames span more than the watchdog, then silence
	task t_wdog;
		wake();
		repeat (4) frm(fw(4'h6, 9'h000));
		chk(failsafe === 1'b0 && failsafe_flag_n === 1'b1, "alive");
		cyc_n(500);
		chk(failsafe === 1'b1 && failsafe_flag_n === 1'b0, "lost");
		// Frames keep coming but the first bit never flips
		wake();
		repeat (4) begin
			mcu.wd_ff = 1'b1;
			frm(fw(4'h6, 9'h000));
		end
		chk(failsafe === 1'b1 && failsafe_flag_n === 1'b0, "untoggled");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		reset_wake_n = 1'b0;
		pwm_clk_in = 1'b0;
		pwm_run = 1'b1;
		vdd_present = 1'b1;
		oc_window = 1'b0;
		direct_in = 2'b00;
		load_type_select = 2'b11;
		sense_valid = 2'b00;
		fault_in = '0;
		sdo_last = 1'b0;
		fail_count = 0;
		checks = 0;
		cyc = 0;
		cyc_n(10);
		reset <= 1'b0;
		t_pins();
		t_regs();
		t_faults();
		t_sense();
		t_wdog();
		stop_test();
	end
endmodule
